// [verilog/tsc_pkg.sv]
package tsc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [14:0] SWITCH_CONTROL_ADDR = 15'h0000;
    localparam logic [15:0] SWITCH_CONTROL_RESET = 16'h0000;
    // Bits held by this block (15 down to 6), the rest read zero
    localparam logic [15:0] SWITCH_CONTROL_MASK = 16'hFFC0;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int JITTER_MODE_HI = 15;
    localparam int JITTER_MODE_LO = 13;
    localparam int SAMPLE_POINT_BIT = 12;
    localparam int RESERVED_BIT = 11;
    localparam int JITTER_ENABLE_BIT = 10;
    localparam int LOCAL_FULL_RATE_BIT = 9;
    localparam int PULSE_WIDTH_BIT = 8;
    localparam int BACKPLANE_FULL_RATE_BIT = 7;
    localparam int CLOCK_EDGE_BIT = 6;

    // ****************************************
    // Field encodings
    // ****************************************
    localparam logic [2:0] JITTER_MODE_LOW_ONLY = 3'h0;
    localparam logic [2:0] JITTER_MODE_BOTH = 3'h7;
    localparam logic [1:0] SAMPLE_AT_3Q = 2'h0;
    localparam logic [1:0] SAMPLE_AT_4Q = 2'h1;
    localparam logic [1:0] SAMPLE_AT_1Q = 2'h2;
    localparam logic [1:0] SAMPLE_AT_2Q = 2'h3;
    localparam logic [15:0] LOCAL_ALL_STREAMS = 16'hFFFF;
    localparam logic [15:0] LOCAL_FULL_RATE_STREAMS = 16'h00FF;
    localparam logic [31:0] BACKPLANE_ALL_STREAMS = 32'hFFFFFFFF;
    localparam logic [31:0] BACKPLANE_FULL_RATE_STREAMS = 32'h0000FFFF;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int PULSE_NARROW_NS = 122;
    localparam int PULSE_WIDE_NS = 244;
    localparam int PULSE_HALF_NS = 61;
    localparam int FRAME_NS = 125000;
    localparam logic [4:0] PULSE_NARROW_CYC = 5'(PULSE_NARROW_NS / CLK_PERIOD_NS);
    localparam logic [4:0] PULSE_WIDE_CYC = 5'(PULSE_WIDE_NS / CLK_PERIOD_NS);
    localparam logic [4:0] PULSE_HALF_CYC = 5'(PULSE_HALF_NS / CLK_PERIOD_NS);
    localparam int FRAME_CYC = FRAME_NS / CLK_PERIOD_NS;
    // Frame boundary acceptance window, in clock cycles ahead of the expected boundary
    localparam logic [15:0] TOL_LOW_JITTER = 16'h0002;
    localparam logic [15:0] TOL_HIGH_JITTER = 16'h0008;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        TSC_BUS_IDLE = 2'b00,
        TSC_BUS_ACK = 2'b01
    } tsc_bus_state_t;

endpackage

// [verilog/tsc_switch_control.sv]
// Overview of operation
// R01: Jitter mode all ones makes the frame discriminator tolerate low and high frequency jitter.
// R02: Jitter mode all zeros handles low frequency jitter only; other codes are not to be written.
// R03: The jitter mode is ignored whenever the discriminator enable bit is clear.
// R04: Sample mode clear samples at 3/4 bit and bit delay is a quarter-bit count 0 to 7 3/4.
// R05: Sample mode set picks a 3/4, 4/4, 1/4 or 2/4 sample point plus 0 to 7 whole bits delay.
// R06: Software keeps bit 11 at zero, its reset value.
// R07: Bit 10 enables the discriminator, which tolerates inconsistent frame boundaries.
// R08: Local full rate clear lets all sixteen local streams run at 2, 4, 8 or 16 Mbps.
// R09: Local full rate set runs local streams 0 to 7 at 32.768 Mbps and leaves 8 to 15 unused.
// R10: Pulse width clear expects a 122 ns input pulse and makes 122 ns and 61 ns output pulses.
// R11: Pulse width set expects a 244 ns input pulse and makes 244 ns and 122 ns output pulses.
// R12: Backplane full rate clear lets all 32 backplane streams run at 2, 4, 8 or 16 Mbps.
// R13: Backplane full rate set runs streams 0 to 15 at 32.768 Mbps and leaves 16 to 31 unused.
// R14: The frame boundary aligns to the falling clock edge when the edge bit is clear, else rising.
// R15: The host selects this register with the top address bit low and all others zero.
// R16: Fields reset to zero, read back as written, and take effect at the next frame boundary.
module tsc_switch_control #(
    parameter int FRAME_CYCLES = tsc_pkg::FRAME_CYC
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [14:0] hostAddr,
    input wire logic [15:0] hostDataIn,
    output logic [15:0] hostDataOut,
    output logic hostDataOe,
    input wire logic hostCsN,
    input wire logic hostDsN,
    input wire logic hostRw,
    output logic hostAckN,
    input wire logic inputClock8m,
    input wire logic framePulseInN,
    input wire logic [4:0] bitDelayIn,
    output logic frameBoundary,
    output logic framePulseOut8mN,
    output logic framePulseOut16mN,
    output logic discriminatorLocked,
    output logic highJitterActive,
    output logic [1:0] samplePoint,
    output logic [2:0] wholeBitDelay,
    output logic [4:0] quarterBitDelay,
    output logic localFullRate,
    output logic backplaneFullRate,
    output logic [15:0] localStreamEnable,
    output logic [31:0] backplaneStreamEnable
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [14:0] addrMeta;
        logic [14:0] addrSync;
        logic [15:0] dataMeta;
        logic [15:0] dataSync;
        logic [2:0] busMeta;
        logic [2:0] busSync;
        logic clkMeta;
        logic clkSync;
        logic clkPrev;
        logic fpMeta;
        logic fpSync;
        logic fpArmed;
        tsc_pkg::tsc_bus_state_t busState;
        logic [15:0] ctrlWritten;
        logic [15:0] ctrlActive;
        logic [15:0] frameCnt;
        logic locked;
        logic [4:0] pulse8Cnt;
        logic [4:0] pulse16Cnt;
        logic fp8OutN;
        logic fp16OutN;
        logic [15:0] readData;
        logic readOe;
        logic ackN;
        logic boundary;
        logic [1:0] smpPoint;
        logic [2:0] wholeDly;
        logic [4:0] quarterDly;
    } tsc_state_t;

    tsc_state_t cur_ff;
    tsc_state_t nxt_ff;

    logic accessReq;
    logic regSelected;
    logic clkEdge;
    logic pulseSeen;
    logic [2:0] effJitterMode;
    logic [15:0] tolerance;
    logic inWindow;
    logic flywheel;
    logic takeBoundary;
    logic [15:0] frameLast;

    // ****************************************
    // Decode of the active settings
    // ****************************************
    always_comb begin
        // Disabled discriminator or a reserved code falls back to low jitter
        if (cur_ff.ctrlActive[tsc_pkg::JITTER_ENABLE_BIT] &&
            cur_ff.ctrlActive[tsc_pkg::JITTER_MODE_HI:tsc_pkg::JITTER_MODE_LO] ==
            tsc_pkg::JITTER_MODE_BOTH) begin // R01 R03
            effJitterMode = tsc_pkg::JITTER_MODE_BOTH;
        end else begin
            effJitterMode = tsc_pkg::JITTER_MODE_LOW_ONLY; // R02 R03
        end
        if (effJitterMode == tsc_pkg::JITTER_MODE_BOTH) begin
            tolerance = tsc_pkg::TOL_HIGH_JITTER; // R01
        end else begin
            tolerance = tsc_pkg::TOL_LOW_JITTER; // R02
        end
    end

    // Bus access and frame pulse edge detection
    always_comb begin
        accessReq = !cur_ff.busSync[0] && !cur_ff.busSync[1];
        regSelected = cur_ff.addrSync == tsc_pkg::SWITCH_CONTROL_ADDR; // R15
        if (cur_ff.ctrlActive[tsc_pkg::CLOCK_EDGE_BIT]) begin
            clkEdge = cur_ff.clkSync && !cur_ff.clkPrev; // R14
        end else begin
            clkEdge = !cur_ff.clkSync && cur_ff.clkPrev; // R14
        end
        pulseSeen = clkEdge && !cur_ff.fpSync && cur_ff.fpArmed;
        frameLast = 16'(FRAME_CYCLES - 1);
        inWindow = (cur_ff.frameCnt + tolerance >= frameLast) ||
            (cur_ff.frameCnt <= tolerance);
        flywheel = cur_ff.frameCnt == frameLast;
    end

    // Frame boundary acceptance by the discriminator
    always_comb begin
        if (!cur_ff.ctrlActive[tsc_pkg::JITTER_ENABLE_BIT]) begin
            takeBoundary = pulseSeen; // R07
        end else if (!cur_ff.locked) begin
            takeBoundary = pulseSeen;
        end else begin
            // Stray pulses outside the window are ignored
            takeBoundary = (pulseSeen && inWindow && cur_ff.frameCnt > tolerance) ||
                (flywheel && !pulseSeen); // R07
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        nxt_ff = cur_ff;
        // Two-stage synchronisers for the host bus, clock and frame pulse pins
        nxt_ff.addrMeta = hostAddr;
        nxt_ff.addrSync = cur_ff.addrMeta;
        nxt_ff.dataMeta = hostDataIn;
        nxt_ff.dataSync = cur_ff.dataMeta;
        nxt_ff.busMeta = {hostRw, hostDsN, hostCsN};
        nxt_ff.busSync = cur_ff.busMeta;
        nxt_ff.clkMeta = inputClock8m;
        nxt_ff.clkSync = cur_ff.clkMeta;
        nxt_ff.clkPrev = cur_ff.clkSync;
        nxt_ff.fpMeta = framePulseInN;
        nxt_ff.fpSync = cur_ff.fpMeta;

        // One boundary per input pulse, rearmed once the pulse ends
        if (cur_ff.fpSync) begin
            nxt_ff.fpArmed = 1'b1;
        end else if (pulseSeen) begin
            nxt_ff.fpArmed = 1'b0;
        end

        // Host bus slave
        case (cur_ff.busState)
            tsc_pkg::TSC_BUS_IDLE: begin
                if (accessReq) begin
                    if (cur_ff.busSync[2]) begin
                        nxt_ff.readData = regSelected ? cur_ff.ctrlWritten : 16'h0000; // R16
                        nxt_ff.readOe = 1'b1;
                    end else if (regSelected) begin
                        // Bit 11 is stored for read-back but has no effect
                        nxt_ff.ctrlWritten = cur_ff.dataSync &
                            tsc_pkg::SWITCH_CONTROL_MASK; // R06 R16
                    end
                    nxt_ff.ackN = 1'b0;
                    nxt_ff.busState = tsc_pkg::TSC_BUS_ACK;
                end
            end
            tsc_pkg::TSC_BUS_ACK: begin
                if (cur_ff.busSync[0] || cur_ff.busSync[1]) begin
                    nxt_ff.ackN = 1'b1;
                    nxt_ff.readOe = 1'b0;
                    nxt_ff.readData = 16'h0000;
                    nxt_ff.busState = tsc_pkg::TSC_BUS_IDLE;
                end
            end
            default: begin
                nxt_ff.ackN = 1'b1;
                nxt_ff.readOe = 1'b0;
                nxt_ff.busState = tsc_pkg::TSC_BUS_IDLE;
            end
        endcase

        // Frame counter and discriminator lock
        nxt_ff.boundary = takeBoundary;
        if (takeBoundary) begin
            nxt_ff.frameCnt = 16'h0000;
            nxt_ff.locked = cur_ff.ctrlActive[tsc_pkg::JITTER_ENABLE_BIT]; // R07
            // New settings take effect here
            nxt_ff.ctrlActive = cur_ff.ctrlWritten; // R16
        end else if (cur_ff.frameCnt != 16'hFFFF) begin
            nxt_ff.frameCnt = cur_ff.frameCnt + 16'h0001;
        end
        if (!cur_ff.ctrlActive[tsc_pkg::JITTER_ENABLE_BIT]) begin
            nxt_ff.locked = 1'b0;
        end

        // Output frame pulses, width from the pulse width bit
        if (takeBoundary) begin
            if (cur_ff.ctrlWritten[tsc_pkg::PULSE_WIDTH_BIT]) begin
                nxt_ff.pulse8Cnt = tsc_pkg::PULSE_WIDE_CYC; // R11
                nxt_ff.pulse16Cnt = tsc_pkg::PULSE_NARROW_CYC; // R11
            end else begin
                nxt_ff.pulse8Cnt = tsc_pkg::PULSE_NARROW_CYC; // R10
                nxt_ff.pulse16Cnt = tsc_pkg::PULSE_HALF_CYC; // R10
            end
        end else begin
            if (cur_ff.pulse8Cnt != 5'h00) begin
                nxt_ff.pulse8Cnt = cur_ff.pulse8Cnt - 5'h01;
            end
            if (cur_ff.pulse16Cnt != 5'h00) begin
                nxt_ff.pulse16Cnt = cur_ff.pulse16Cnt - 5'h01;
            end
        end

        // Frame pulse pins, registered together with their counters
        nxt_ff.fp8OutN = nxt_ff.pulse8Cnt == 5'h00; // R10 R11
        nxt_ff.fp16OutN = nxt_ff.pulse16Cnt == 5'h00; // R10 R11

        // Input bit delay translation
        if (cur_ff.ctrlActive[tsc_pkg::SAMPLE_POINT_BIT]) begin
            case (bitDelayIn[1:0]) // R05
                2'h0: nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_3Q;
                2'h1: nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_4Q;
                2'h2: nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_1Q;
                2'h3: nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_2Q;
                default: nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_3Q;
            endcase
            nxt_ff.wholeDly = bitDelayIn[4:2]; // R05
            nxt_ff.quarterDly = {bitDelayIn[4:2], 2'b00}; // R05
        end else begin
            nxt_ff.smpPoint = tsc_pkg::SAMPLE_AT_3Q; // R04
            nxt_ff.wholeDly = bitDelayIn[4:2]; // R04
            nxt_ff.quarterDly = bitDelayIn; // R04
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cur_ff <= '0;
            cur_ff.busMeta <= 3'h7;
            cur_ff.busSync <= 3'h7;
            cur_ff.fpMeta <= 1'b1;
            cur_ff.fpSync <= 1'b1;
            cur_ff.fp8OutN <= 1'b1;
            cur_ff.fp16OutN <= 1'b1;
            cur_ff.ackN <= 1'b1;
            cur_ff.busState <= tsc_pkg::TSC_BUS_IDLE;
            cur_ff.ctrlWritten <= tsc_pkg::SWITCH_CONTROL_RESET; // R16
            cur_ff.ctrlActive <= tsc_pkg::SWITCH_CONTROL_RESET; // R16
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic [15:0] localEnFf;
    logic [31:0] backEnFf;
    logic highJitFf;

    // Stream enables and jitter mode, registered
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            localEnFf <= tsc_pkg::LOCAL_ALL_STREAMS;
            backEnFf <= tsc_pkg::BACKPLANE_ALL_STREAMS;
            highJitFf <= 1'b0;
        end else begin
            localEnFf <= cur_ff.ctrlActive[tsc_pkg::LOCAL_FULL_RATE_BIT] ?
                tsc_pkg::LOCAL_FULL_RATE_STREAMS : tsc_pkg::LOCAL_ALL_STREAMS; // R08 R09
            backEnFf <= cur_ff.ctrlActive[tsc_pkg::BACKPLANE_FULL_RATE_BIT] ?
                tsc_pkg::BACKPLANE_FULL_RATE_STREAMS :
                tsc_pkg::BACKPLANE_ALL_STREAMS; // R12 R13
            highJitFf <= effJitterMode == tsc_pkg::JITTER_MODE_BOTH; // R01
        end
    end

    assign hostDataOut = cur_ff.readData;
    assign hostDataOe = cur_ff.readOe;
    assign hostAckN = cur_ff.ackN;
    assign frameBoundary = cur_ff.boundary;
    assign framePulseOut8mN = cur_ff.fp8OutN;
    assign framePulseOut16mN = cur_ff.fp16OutN;
    assign discriminatorLocked = cur_ff.locked;
    assign highJitterActive = highJitFf;
    assign samplePoint = cur_ff.smpPoint;
    assign wholeBitDelay = cur_ff.wholeDly;
    assign quarterBitDelay = cur_ff.quarterDly;
    assign localFullRate = cur_ff.ctrlActive[tsc_pkg::LOCAL_FULL_RATE_BIT];
    assign backplaneFullRate = cur_ff.ctrlActive[tsc_pkg::BACKPLANE_FULL_RATE_BIT];
    assign localStreamEnable = localEnFf;
    assign backplaneStreamEnable = backEnFf;

endmodule

// [bench/tsc_switch_control_monitor.sv]
module tsc_switch_control_monitor #(
    parameter int FRAME_CYCLES = 200
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic hostCsN,
    input wire logic hostDsN,
    input wire logic [15:0] hostDataOut,
    input wire logic hostDataOe,
    input wire logic hostAckN,
    input wire logic frameBoundary,
    input wire logic framePulseOut8mN,
    input wire logic framePulseOut16mN,
    input wire logic [1:0] samplePoint,
    input wire logic [2:0] wholeBitDelay,
    input wire logic [4:0] quarterBitDelay,
    input wire logic localFullRate,
    input wire logic backplaneFullRate,
    input wire logic [15:0] localStreamEnable,
    input wire logic [31:0] backplaneStreamEnable
);
    // ****************************************
    // Port checks
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_ack_select;
        $fell(hostAckN) |-> !$past(hostCsN, 3) && !$past(hostDsN, 3);
    endproperty
    a_ack_select: assert property (p_ack_select) else $error("ack without select");
    property p_ack_release;
        $rose(hostAckN) |-> $past(hostCsN, 3) || $past(hostDsN, 3);
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack dropped early");
    property p_idle_data;
        !hostDataOe |-> hostDataOut == 16'h0000;
    endproperty
    a_idle_data: assert property (p_idle_data) else $error("data while idle");
    property p_fb_single;
        frameBoundary |=> !frameBoundary;
    endproperty
    a_fb_single: assert property (p_fb_single) else $error("boundary too long");
    property p_narrow;
        frameBoundary ##6 framePulseOut16mN |-> !framePulseOut8mN [*6] ##1 framePulseOut8mN;
    endproperty
    a_narrow: assert property (p_narrow) else $error("narrow pulse width");
    property p_wide;
        frameBoundary ##6 !framePulseOut16mN |->
            ##6 (framePulseOut16mN && !framePulseOut8mN) ##12 framePulseOut8mN;
    endproperty
    a_wide: assert property (p_wide) else $error("wide pulse width");
    property p_local;
        localStreamEnable == ($past(localFullRate) ? 16'h00FF : 16'hFFFF);
    endproperty
    a_local: assert property (p_local) else $error("local streams");
    property p_backplane;
        backplaneStreamEnable == ($past(backplaneFullRate) ? 32'h0000FFFF : 32'hFFFFFFFF);
    endproperty
    a_backplane: assert property (p_backplane) else $error("backplane streams");
    property p_sample;
        samplePoint != 2'h0 |-> quarterBitDelay == {wholeBitDelay, 2'h0};
    endproperty
    a_sample: assert property (p_sample) else $error("whole bit delay");

    // Main scenarios seen
    c_boundary: cover property (frameBoundary);
    c_read: cover property ($rose(hostDataOe));
    c_wide: cover property (frameBoundary ##6 !framePulseOut16mN);
endmodule

bind tsc_switch_control tsc_switch_control_monitor #(.FRAME_CYCLES(FRAME_CYCLES)) u_mon (
    .mclk(mclk), .sys_rst(sys_rst), .hostCsN(hostCsN), .hostDsN(hostDsN),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .hostAckN(hostAckN),
    .frameBoundary(frameBoundary), .framePulseOut8mN(framePulseOut8mN),
    .framePulseOut16mN(framePulseOut16mN), .samplePoint(samplePoint),
    .wholeBitDelay(wholeBitDelay), .quarterBitDelay(quarterBitDelay),
    .localFullRate(localFullRate), .backplaneFullRate(backplaneFullRate),
    .localStreamEnable(localStreamEnable), .backplaneStreamEnable(backplaneStreamEnable)
);

// [bench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int FRAME = 200;
    logic mclk = 1'b0, sys_rst = 1'b1, hostCsN = 1'b1, hostDsN = 1'b1, hostRw = 1'b1;
    logic inputClock8m = 1'b0, framePulseInN = 1'b1, hit;
    logic [14:0] hostAddr = 15'h0000;
    logic [15:0] hostDataIn = 16'h0000, hostDataOut, rd, localStreamEnable;
    logic [4:0] bitDelayIn = 5'h00, quarterBitDelay;
    logic hostDataOe, hostAckN, frameBoundary, framePulseOut8mN, framePulseOut16mN;
    logic discriminatorLocked, highJitterActive, localFullRate, backplaneFullRate;
    logic [1:0] samplePoint;
    logic [2:0] wholeBitDelay;
    logic [31:0] backplaneStreamEnable;
    int error_cnt = 0, comparisons = 0, cyc = 0, lastFb = 0, n8, n16, b0;

    tsc_switch_control #(.FRAME_CYCLES(FRAME)) u_dut (.mclk(mclk), .sys_rst(sys_rst),
        .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
        .hostDataOe(hostDataOe), .hostCsN(hostCsN), .hostDsN(hostDsN), .hostRw(hostRw),
        .hostAckN(hostAckN), .inputClock8m(inputClock8m), .framePulseInN(framePulseInN),
        .bitDelayIn(bitDelayIn), .frameBoundary(frameBoundary),
        .framePulseOut8mN(framePulseOut8mN), .framePulseOut16mN(framePulseOut16mN),
        .discriminatorLocked(discriminatorLocked), .highJitterActive(highJitterActive),
        .samplePoint(samplePoint), .wholeBitDelay(wholeBitDelay),
        .quarterBitDelay(quarterBitDelay), .localFullRate(localFullRate),
        .backplaneFullRate(backplaneFullRate), .localStreamEnable(localStreamEnable),
        .backplaneStreamEnable(backplaneStreamEnable));

    // ****************************************
    // Clock, cycle count, helpers
    // ****************************************
    always #5 mclk = ~mclk;

    // Cycle of the latest frame boundary
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (frameBoundary === 1'b1) begin
            lastFb <= cyc;
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("error_cnt %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One host access, held until acknowledge, then released
    task automatic host(input logic rw, input logic [14:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(negedge mclk);
        hostRw = rw;
        hostAddr = a;
        hostDataIn = d;
        hostCsN = 1'b0;
        hostDsN = 1'b0;
        // Acknowledge looked at between edges, where it is settled
        do begin
            @(negedge mclk);
            n++;
        end while (hostAckN !== 1'b0 && n < 20);
        rd = hostDataOut;
        check(n, 3, "ack delay");
        check(hostDataOe, rw, "data enable");
        @(negedge mclk);
        hostCsN = 1'b1;
        hostDsN = 1'b1;
        n = 0;
        while (hostAckN !== 1'b1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        check(n < 20, 1, "ack release");
    endtask

    // Frame pulse with one chosen clock edge inside it; measures outputs
    task automatic send(input logic rise, input int w);
        @(negedge mclk);
        inputClock8m = ~rise;
        @(negedge mclk);
        framePulseInN = 1'b0;
        @(negedge mclk);
        inputClock8m = rise;
        // Boundary shows after the third edge
        repeat (3) @(posedge mclk);
        n8 = 0;
        n16 = 0;
        for (int i = 0; i < 30; i++) begin
            @(negedge mclk);
            if (i == 0) hit = frameBoundary;
            n8 += int'(framePulseOut8mN === 1'b0);
            n16 += int'(framePulseOut16mN === 1'b0);
            // Pin pulse lasts w + 1 cycles: 120 ns or 240 ns
            if (i == w - 3) framePulseInN = 1'b1;
        end
    endtask

    // Pulse arriving d cycles ahead of the expected boundary
    task automatic early(input int d);
        while (cyc < lastFb + FRAME - d - 6) @(negedge mclk);
        send(1'b0, 11);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        host(1, 15'h0000, 16'h0000);
        check(rd, 16'h0000, "reset value");
        check(localStreamEnable, 16'hFFFF, "reset local");
        check(backplaneStreamEnable, 32'hFFFFFFFF, "reset backplane");
        // Bit 11 always written as zero
        host(0, 15'h0000, 16'hF7FF);
        host(1, 15'h0000, 16'h0000);
        check(rd, 16'hF7C0, "read back");
        host(0, 15'h0000, 16'h0000);
        host(0, 15'h0001, 16'hFFFF);
        host(1, 15'h0000, 16'h0000);
        check(rd, 16'h0000, "reserved bit kept");
        host(1, 15'h4000, 16'h0000);
        check(rd, 16'h0000, "memory space");
        host(1, 15'h0001, 16'h0000);
        check(rd, 16'h0000, "unmapped");
    endtask

    task automatic t_rates();
        host(0, 15'h0000, 16'h0280);
        check(localStreamEnable, 16'hFFFF, "before boundary");
        send(1'b0, 11);
        check(hit, 1, "boundary");
        check(n8, 12, "narrow 8m");
        check(n16, 6, "narrow 16m");
        check(localStreamEnable, 16'h00FF, "local full");
        check(backplaneStreamEnable, 32'h0000FFFF, "backplane full");
        check(localFullRate, 1, "local mode");
        check(backplaneFullRate, 1, "backplane mode");
        host(0, 15'h0000, 16'h0100);
        send(1'b0, 23);
        check(n8, 24, "wide 8m");
        check(n16, 12, "wide 16m");
        check(localStreamEnable, 16'hFFFF, "local split");
        check(backplaneStreamEnable, 32'hFFFFFFFF, "backplane split");
        check(localFullRate, 0, "local mode off");
        check(backplaneFullRate, 0, "backplane mode off");
    endtask

    task automatic t_edge();
        send(1'b1, 11);
        check(hit, 0, "rising ignored");
        // Edge bit takes effect only at the boundary after the write
        host(0, 15'h0000, 16'h0040);
        send(1'b0, 11);
        check(hit, 1, "old edge kept");
        send(1'b0, 11);
        check(hit, 0, "falling ignored");
        send(1'b1, 11);
        check(hit, 1, "rising taken");
        host(0, 15'h0000, 16'h0000);
        send(1'b1, 11);
        check(hit, 1, "rising kept");
        send(1'b0, 11);
        check(hit, 1, "falling taken");
    endtask

    task automatic t_sample();
        for (int m = 0; m < 2; m++) begin
            host(0, 15'h0000, (m == 1) ? 16'h1000 : 16'h0000);
            send(1'b0, 11);
            for (int v = 0; v < 32; v++) begin
                @(negedge mclk);
                bitDelayIn = v[4:0];
                @(negedge mclk);
                check(samplePoint, (m == 1) ? v[1:0] : 2'h0, "sample point");
                check(wholeBitDelay, v[4:2], "whole bits");
                check(quarterBitDelay, (m == 1) ? {v[4:2], 2'h0} : v[4:0], "quarters");
            end
        end
    endtask

    task automatic t_jitter();
        host(0, 15'h0000, 16'hE000);
        send(1'b0, 11);
        check(highJitterActive, 0, "mode ignored");
        // First boundary enables, the second one locks
        host(0, 15'h0000, 16'h0400);
        send(1'b0, 11);
        send(1'b0, 11);
        check(discriminatorLocked, 1, "locked");
        check(highJitterActive, 0, "low jitter");
        b0 = lastFb;
        early(5);
        check(hit, 0, "narrow window");
        check(lastFb > b0, 1, "flywheel");
        host(0, 15'h0000, 16'hE400);
        // Wait past the next flywheel boundary, counted from a fixed point
        b0 = lastFb;
        while (cyc < b0 + FRAME + 10) @(negedge mclk);
        check(highJitterActive, 1, "high jitter");
        early(5);
        check(hit, 1, "wide window");
        early(20);
        check(hit, 0, "outside window");
    endtask

    // Main sequence
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 1'b0;
        t_regs();
        t_rates();
        t_edge();
        t_sample();
        t_jitter();
        end_of_test();
    end

    // Watchdog
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
endmodule
